// ---- rtl/pp_defines.vh ----
// Constants for the parallel nonvolatile programming port.
// Included by the port modules; holds definitions only.
`ifndef PP_DEFINES_VH
`define PP_DEFINES_VH

// Clock and timing.
`define PP_CLK_PERIOD_NS 50
`define PP_SETTLE_NS 100
`define PP_SETTLE_CYCLES ((`PP_SETTLE_NS + `PP_CLK_PERIOD_NS - 1) / `PP_CLK_PERIOD_NS)
`define PP_FUSE_WRITE_NS 4500000
`define PP_FUSE_WRITE_CYCLES (`PP_FUSE_WRITE_NS / `PP_CLK_PERIOD_NS)
`define PP_ENTRY_TOGGLES 3'h6

// Commands.
`define PP_CMD_READ_FLASH 8'h02
`define PP_CMD_READ_EEPROM 8'h03
`define PP_CMD_READ_FUSE_LOW 8'h04
`define PP_CMD_WRITE_FUSE_LOW 8'h40

// Action select codes on the two action pins.
`define PP_ACT_LOAD_ADDR 2'h0
`define PP_ACT_LOAD_DATA 2'h1
`define PP_ACT_LOAD_CMD 2'h2

// Memory organisation.
`define PP_FLASH_WORDS 4096
`define PP_PROGRAM_COUNTER_TOP_BIT 11
`define PP_WORD_IN_PAGE_HI 4
`define PP_PAGE_NUMBER_LO 5
`define PP_EEPROM_BYTES 512
`define PP_NV_BYTE_ADDRESS_TOP_BIT 8
`define PP_EE_BYTE_IN_PAGE_HI 1
`define PP_EE_PAGE_LO 2
`define PP_ERASED_BYTE 8'hFF
`define PP_ERASED_WORD 16'hFFFF
`define PP_FUSE_LOW_RESET 8'hFF
`define PP_ENTRY_PINS_IDLE 4'h0
// Idle levels of the synchronised pin bundle; write strobe and output enable rest high.
`define PP_SYNC_IDLE 20'h00300

`endif

// ---- rtl/pp_port.v ----
// Parallel programming port: mode entry, command and address latches, flash,
// EEPROM and fuse reads, and the low fuse byte write with ready/busy handshake.
// Assumes all pins come from an external programmer asynchronous to sys_clk.
`timescale 1ns/10ps
`default_nettype none
`include "pp_defines.vh"

// Contract
// - Entry-select change within 100 ns after high voltage refuses programming mode.
// - Last command and address stay latched across later operations.
// - Address high byte selects a 256-location window, reloaded only when moving.
// - Flash read is command 0000 0010 then high and low address bytes.
// - Flash read drives low byte for byte select 0, high byte for 1.
// - EEPROM read is command 0000 0011; byte driven with select 0.
// - Low fuse write is command 0100 0000 plus one data low byte.
// - Fuse data bit 0 programs the fuse, bit 1 erases it.
// - Write strobe low pulse starts fuse write; wait for ready high.
// - Programmed fuse bits read 0, unprogrammed bits read 1.
// - Flash is 128 pages of 32 words; bits 4:0 word, 11:5 page.
// - EEPROM is 128 pages of 4 bytes; bits 1:0 byte, 8:2 page.
module pp_port #(
    parameter FUSE_WRITE_CYCLES = `PP_FUSE_WRITE_CYCLES
) (
    input wire sys_clk,
    input wire reset,
    input wire resetPinLow,
    input wire highVoltageOnReset,
    input wire [3:0] progEnable,
    input wire programmingClockPin,
    input wire [1:0] actionSelect,
    input wire byteSelectOne,
    input wire writeStrobeLow,
    input wire outputEnableLow,
    input wire [7:0] dataIn,
    output reg [7:0] dataOut,
    output reg dataOutEnable,
    output reg readyBusyPin,
    output reg progModeActive,
    output reg entryRefused
);

    localparam [3:0] ST_WAIT = 4'h1;
    localparam [3:0] ST_SETTLE = 4'h2;
    localparam [3:0] ST_ACTIVE = 4'h4;
    localparam [3:0] ST_REFUSED = 4'h8;
    localparam integer SETTLE_LAST = `PP_SETTLE_CYCLES - 1;
    // The busy counter runs from WRITE_LAST down to zero, so busy lasts FUSE_WRITE_CYCLES cycles.
    localparam integer WRITE_LAST = FUSE_WRITE_CYCLES - 1;

    function isReadCommand;
        input [7:0] cmd;
        begin
            isReadCommand = (cmd == `PP_CMD_READ_FLASH) || (cmd == `PP_CMD_READ_EEPROM) ||
                (cmd == `PP_CMD_READ_FUSE_LOW);
        end
    endfunction

    wire [19:0] syncBundle;
    wire syncResetLow;
    wire syncHighVoltage;
    wire [3:0] syncProgEnable;
    wire syncProgClk;
    wire [1:0] syncAction;
    wire syncByteSelect;
    wire syncWriteLow;
    wire syncOutputLow;
    wire [7:0] syncData;

    // Resetting the stages to the pin idle levels keeps the edge detectors from seeing a false edge.
    pp_sync #(
        .WIDTH(20),
        .RESET_VALUE(`PP_SYNC_IDLE)
    ) uSync (
        .sys_clk(sys_clk),
        .reset(reset),
        .asyncIn({resetPinLow, highVoltageOnReset, progEnable, programmingClockPin, actionSelect,
            byteSelectOne, writeStrobeLow, outputEnableLow, dataIn}),
        .syncOut(syncBundle)
    );

    assign {syncResetLow, syncHighVoltage, syncProgEnable, syncProgClk, syncAction,
        syncByteSelect, syncWriteLow, syncOutputLow, syncData} = syncBundle;

    reg [3:0] state;
    reg [3:0] next_state;
    reg [2:0] toggleCount;
    reg [1:0] settleCount;
    reg progClkPrev;
    reg writeLowPrev;
    reg [7:0] command;
    reg [7:0] addrHigh;
    reg [7:0] addrLow;
    reg [7:0] dataLow;
    reg [7:0] fuseLow;
    reg [7:0] pendingFuse;
    reg [16:0] writeCount;
    reg [15:0] flashMem [0:`PP_FLASH_WORDS-1];
    reg [7:0] eepromMem [0:`PP_EEPROM_BYTES-1];

    wire progClkRise = syncProgClk && !progClkPrev;
    wire progClkEdge = syncProgClk != progClkPrev;
    wire writeFall = writeLowPrev && !syncWriteLow;
    wire inActive = (state == ST_ACTIVE);

    // The retained high byte picks the window, the low byte the location in it.
    wire [15:0] fullAddress = {addrHigh, addrLow};
    wire [`PP_WORD_IN_PAGE_HI:0] wordInPageIndex = fullAddress[`PP_WORD_IN_PAGE_HI:0];
    wire [`PP_PROGRAM_COUNTER_TOP_BIT-`PP_PAGE_NUMBER_LO:0] pageNumberIndex =
        fullAddress[`PP_PROGRAM_COUNTER_TOP_BIT:`PP_PAGE_NUMBER_LO];
    wire [`PP_PROGRAM_COUNTER_TOP_BIT:0] flashWordAddr = {pageNumberIndex, wordInPageIndex};
    wire [`PP_EE_BYTE_IN_PAGE_HI:0] eeByteInPage = fullAddress[`PP_EE_BYTE_IN_PAGE_HI:0];
    wire [`PP_NV_BYTE_ADDRESS_TOP_BIT-`PP_EE_PAGE_LO:0] eePageIndex =
        fullAddress[`PP_NV_BYTE_ADDRESS_TOP_BIT:`PP_EE_PAGE_LO];
    wire [`PP_NV_BYTE_ADDRESS_TOP_BIT:0] nvByteAddress = {eePageIndex, eeByteInPage};

    // Memories start in the erased state.
    integer k;
    initial begin
        for (k = 0; k < `PP_FLASH_WORDS; k = k + 1) begin
            flashMem[k] = `PP_ERASED_WORD;
        end
        for (k = 0; k < `PP_EEPROM_BYTES; k = k + 1) begin
            eepromMem[k] = `PP_ERASED_BYTE;
        end
    end

    always @(posedge sys_clk) begin
        if (reset) begin
            progClkPrev <= 1'b0;
            writeLowPrev <= 1'b1;
        end else begin
            progClkPrev <= syncProgClk;
            writeLowPrev <= syncWriteLow;
        end
    end

    // Mode entry sequencing.
    always @* begin
        next_state = state;
        case (state)
            ST_WAIT: begin
                if (syncHighVoltage && !syncResetLow) begin
                    if (toggleCount >= `PP_ENTRY_TOGGLES && syncProgEnable == `PP_ENTRY_PINS_IDLE) begin
                        next_state = ST_SETTLE;
                    end else begin
                        next_state = ST_REFUSED;
                    end
                end
            end
            ST_SETTLE: begin
                if (!syncHighVoltage) begin
                    next_state = ST_WAIT;
                end else if (syncProgEnable != `PP_ENTRY_PINS_IDLE) begin
                    next_state = ST_REFUSED;
                end else if (settleCount == SETTLE_LAST[1:0]) begin
                    next_state = ST_ACTIVE;
                end
            end
            ST_ACTIVE: begin
                if (!syncHighVoltage) begin
                    next_state = ST_WAIT;
                end
            end
            ST_REFUSED: begin
                if (!syncHighVoltage) begin
                    next_state = ST_WAIT;
                end
            end
            default: begin
                next_state = ST_WAIT;
            end
        endcase
    end

    // Clock pin changes are counted only while the reset pin is held low in the wait state.
    always @(posedge sys_clk) begin
        if (reset) begin
            state <= ST_WAIT;
            toggleCount <= 3'h0;
            settleCount <= 2'h0;
        end else begin
            state <= next_state;
            if (state == ST_WAIT && syncResetLow) begin
                if (progClkEdge && toggleCount != 3'h7) begin
                    toggleCount <= toggleCount + 3'h1;
                end
            end else if (state != ST_WAIT) begin
                toggleCount <= 3'h0;
            end
            if (state == ST_SETTLE) begin
                settleCount <= settleCount + 2'h1;
            end else begin
                settleCount <= 2'h0;
            end
        end
    end

    // Mode flags are registered from the next state so that they change together with it.
    always @(posedge sys_clk) begin
        if (reset) begin
            progModeActive <= 1'b0;
            entryRefused <= 1'b0;
        end else begin
            progModeActive <= (next_state == ST_ACTIVE);
            entryRefused <= (next_state == ST_REFUSED);
        end
    end

    // Command, address and data latches; loads are ignored while busy.
    always @(posedge sys_clk) begin
        if (reset) begin
            command <= 8'h00;
            addrHigh <= 8'h00;
            addrLow <= 8'h00;
            dataLow <= 8'h00;
        end else if (inActive && readyBusyPin && progClkRise) begin
            case (syncAction)
                `PP_ACT_LOAD_CMD: begin
                    command <= syncData;
                end
                `PP_ACT_LOAD_ADDR: begin
                    if (syncByteSelect) begin
                        addrHigh <= syncData;
                    end else begin
                        addrLow <= syncData;
                    end
                end
                `PP_ACT_LOAD_DATA: begin
                    if (!syncByteSelect) begin
                        dataLow <= syncData;
                    end
                end
                default: begin
                    command <= command;
                end
            endcase
        end
    end

    // Fuse write: the strobe starts it, ready/busy stays low until it is done.
    // A fuse bit written as 0 is programmed and reads back as 0 afterwards.
    always @(posedge sys_clk) begin
        if (reset) begin
            readyBusyPin <= 1'b1;
            writeCount <= 17'h00000;
            pendingFuse <= 8'h00;
            fuseLow <= `PP_FUSE_LOW_RESET;
        end else if (!readyBusyPin) begin
            if (writeCount == 17'h00000) begin
                fuseLow <= pendingFuse;
                readyBusyPin <= 1'b1;
            end else begin
                writeCount <= writeCount - 17'h00001;
            end
        end else if (inActive && writeFall && command == `PP_CMD_WRITE_FUSE_LOW) begin
            pendingFuse <= dataLow;
            writeCount <= WRITE_LAST[16:0];
            readyBusyPin <= 1'b0;
        end
    end

    // Read path: drive the bus only while output enable is low.
    // EEPROM and fuse reads answer only on the low byte select; flash uses both.
    always @(posedge sys_clk) begin
        if (reset) begin
            dataOut <= 8'h00;
            dataOutEnable <= 1'b0;
        end else begin
            dataOutEnable <= 1'b0;
            dataOut <= 8'h00;
            if (inActive && !syncOutputLow && isReadCommand(command)) begin
                case (command)
                    `PP_CMD_READ_FLASH: begin
                        dataOutEnable <= 1'b1;
                        if (syncByteSelect) begin
                            dataOut <= flashMem[flashWordAddr][15:8];
                        end else begin
                            dataOut <= flashMem[flashWordAddr][7:0];
                        end
                    end
                    `PP_CMD_READ_EEPROM: begin
                        if (!syncByteSelect) begin
                            dataOutEnable <= 1'b1;
                            dataOut <= eepromMem[nvByteAddress];
                        end
                    end
                    default: begin
                        if (!syncByteSelect) begin
                            dataOutEnable <= 1'b1;
                            dataOut <= fuseLow;
                        end
                    end
                endcase
            end
        end
    end

endmodule

`default_nettype wire

// ---- rtl/pp_sync.v ----
// Two-flop synchroniser for a bundle of asynchronous pin levels.
// Assumes every bit is an independent level; multi-bit words must be stable when sampled.
// Each stage resets to RESET_VALUE, which should be the idle level of its pin.
`timescale 1ns/10ps
`default_nettype none

module pp_sync #(
    parameter WIDTH = 1,
    parameter [WIDTH-1:0] RESET_VALUE = {WIDTH{1'b0}}
) (
    input wire sys_clk,
    input wire reset,
    input wire [WIDTH-1:0] asyncIn,
    output wire [WIDTH-1:0] syncOut
);

    genvar i;
    generate
        for (i = 0; i < WIDTH; i = i + 1) begin : gBit
            reg stageOne;
            reg stageTwo;
            always @(posedge sys_clk) begin
                if (reset) begin
                    stageOne <= RESET_VALUE[i];
                    stageTwo <= RESET_VALUE[i];
                end else begin
                    stageOne <= asyncIn[i];
                    stageTwo <= stageOne;
                end
            end
            assign syncOut[i] = stageTwo;
        end
    endgenerate

endmodule

`default_nettype wire

// ---- tb/pp_port_asserts.sv ----
// Checker for the programming port pins, bound into pp_port.
// Assumes reset is held for several cycles at a time.
`timescale 1ns/10ps
`default_nettype none
module pp_port_asserts #(
    parameter FUSE_WRITE_CYCLES = 8
) (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic [3:0] progEnable,
    input wire logic highVoltageOnReset,
    input wire logic writeStrobeLow,
    input wire logic outputEnableLow,
    input wire logic [7:0] dataOut,
    input wire logic dataOutEnable,
    input wire logic readyBusyPin,
    input wire logic progModeActive,
    input wire logic entryRefused
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (reset);
    logic [31:0] busyCnt;
    always @(posedge sys_clk) begin
        if (reset || readyBusyPin) begin
            busyCnt <= 32'h0;
        end else begin
            busyCnt <= busyCnt + 32'h1;
        end
    end
    sequence oeIdle;
        outputEnableLow [*5];
    endsequence
    sequence strobeSeen;
        !$past(writeStrobeLow, 2) && progModeActive;
    endsequence
    reset_clears_a: assert property ($fell(reset) |-> !dataOutEnable && readyBusyPin && !progModeActive)
        else $error("outputs not cleared by reset");
    refuse_excl_a: assert property (entryRefused |-> !progModeActive)
        else $error("refused and active together");
    entry_quiet_a: assert property ($rose(progModeActive) |-> $past(progEnable, 2) == 4'h0 && $past(highVoltageOnReset, 2))
        else $error("entry without quiet select pins");
    oe_release_a: assert property (oeIdle |-> !dataOutEnable)
        else $error("bus driven with output enable high");
    drive_cause_a: assert property ($rose(dataOutEnable) |-> !$past(outputEnableLow, 2) && progModeActive)
        else $error("bus driven without output enable");
    released_zero_a: assert property (!dataOutEnable |-> dataOut == 8'h00)
        else $error("released bus not zero");
    idle_no_drive_a: assert property (!progModeActive && !$past(progModeActive) |-> !dataOutEnable)
        else $error("bus driven outside programming mode");
    busy_length_a: assert property ($rose(readyBusyPin) |-> busyCnt == FUSE_WRITE_CYCLES)
        else $error("busy period has wrong length");
    busy_cause_a: assert property ($fell(readyBusyPin) |-> strobeSeen)
        else $error("busy without write strobe");
endmodule
bind pp_port pp_port_asserts #(.FUSE_WRITE_CYCLES(FUSE_WRITE_CYCLES)) chk (
    .sys_clk(sys_clk), .reset(reset), .progEnable(progEnable), .highVoltageOnReset(highVoltageOnReset),
    .writeStrobeLow(writeStrobeLow), .outputEnableLow(outputEnableLow), .dataOut(dataOut),
    .dataOutEnable(dataOutEnable), .readyBusyPin(readyBusyPin), .progModeActive(progModeActive),
    .entryRefused(entryRefused)
);
`default_nettype wire

// ---- tb/pp_prog.sv ----
// Model of the external parallel programmer driving the port pins.
// Assumes the caller runs one task at a time from one process.
`timescale 1ns/10ps
`default_nettype none
module pp_prog (
    input wire logic sys_clk,
    input wire logic [7:0] dataOut,
    input wire logic dataOutEnable,
    input wire logic readyBusyPin,
    output logic resetPinLow,
    output logic highVoltageOnReset,
    output logic [3:0] progEnable,
    output logic programmingClockPin,
    output logic [1:0] actionSelect,
    output logic byteSelectOne,
    output logic writeStrobeLow,
    output logic outputEnableLow,
    output wire logic [7:0] dataIn
);
    logic [7:0] busData;
    // With output enable low and the port not driving, the bus shows the inverse of busData.
    assign dataIn = dataOutEnable ? dataOut : (outputEnableLow ? busData : ~busData);
    initial begin
        {resetPinLow, highVoltageOnReset, programmingClockPin, byteSelectOne} = 4'h0;
        {writeStrobeLow, outputEnableLow} = 2'h3;
        progEnable = 4'hF;
        actionSelect = 2'h3;
        busData = 8'h00;
    end
    task automatic step(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    task automatic enter(input logic [3:0] glitch);
        resetPinLow <= 1'b1;
        repeat (6) begin
            step(4);
            programmingClockPin <= ~programmingClockPin;
        end
        progEnable <= 4'h0;
        step(4);
        highVoltageOnReset <= 1'b1;
        resetPinLow <= 1'b0;
        step(1);
        progEnable <= glitch;
        step(1000);
        progEnable <= 4'h0;
    endtask
    task automatic leave();
        highVoltageOnReset <= 1'b0;
        step(8);
    endtask
    task automatic load(input logic [1:0] act, input logic bs, input logic [7:0] d);
        actionSelect <= act;
        byteSelectOne <= bs;
        busData <= d;
        step(4);
        programmingClockPin <= 1'b1;
        step(4);
        programmingClockPin <= 1'b0;
        step(4);
        actionSelect <= 2'h3;
        step(1);
    endtask
    task automatic read(input logic bs, output logic [7:0] d, output logic en);
        byteSelectOne <= bs;
        outputEnableLow <= 1'b0;
        step(5);
        d = dataOut;
        en = dataOutEnable;
        outputEnableLow <= 1'b1;
        step(6);
    endtask
    task automatic strobe();
        writeStrobeLow <= 1'b0;
        step(4);
        writeStrobeLow <= 1'b1;
        step(1);
    endtask
    task automatic waitReady(output int n);
        n = 0;
        while (readyBusyPin !== 1'b1 && n < 100) begin
            step(1);
            n++;
        end
    endtask
endmodule
`default_nettype wire

// ---- tb/tb.sv ----
// Self-checking bench for pp_port with the programmer model.
// Assumes the fuse write length is shortened to FWC cycles.
`timescale 1ns/10ps
`default_nettype none
module tb;
    localparam int FWC = 8;
    logic sys_clk, reset, resetPinLow, highVoltageOnReset, programmingClockPin, byteSelectOne;
    logic writeStrobeLow, outputEnableLow, dataOutEnable, readyBusyPin, progModeActive, entryRefused;
    logic [3:0] progEnable;
    logic [1:0] actionSelect;
    logic [7:0] dataIn, dataOut, rd;
    logic en;
    int n_errors = 0;
    int samples_checked = 0;
    int cycles = 0;
    int n;
    pp_port #(.FUSE_WRITE_CYCLES(FWC)) dut (
        .sys_clk(sys_clk), .reset(reset), .resetPinLow(resetPinLow), .highVoltageOnReset(highVoltageOnReset),
        .progEnable(progEnable), .programmingClockPin(programmingClockPin), .actionSelect(actionSelect),
        .byteSelectOne(byteSelectOne), .writeStrobeLow(writeStrobeLow), .outputEnableLow(outputEnableLow),
        .dataIn(dataIn), .dataOut(dataOut), .dataOutEnable(dataOutEnable), .readyBusyPin(readyBusyPin),
        .progModeActive(progModeActive), .entryRefused(entryRefused)
    );
    pp_prog prog (
        .sys_clk(sys_clk), .dataOut(dataOut), .dataOutEnable(dataOutEnable), .readyBusyPin(readyBusyPin),
        .resetPinLow(resetPinLow), .highVoltageOnReset(highVoltageOnReset), .progEnable(progEnable),
        .programmingClockPin(programmingClockPin), .actionSelect(actionSelect), .byteSelectOne(byteSelectOne),
        .writeStrobeLow(writeStrobeLow), .outputEnableLow(outputEnableLow), .dataIn(dataIn)
    );
    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_errors++;
            finish_test();
        end
    end
    task automatic t_refuse();
        prog.enter(4'h1);
        check("refused", entryRefused, 8'h01);
        check("active", progModeActive, 8'h00);
        prog.leave();
        $display("test refuse done");
    endtask
    task automatic t_flash();
        prog.enter(4'h0);
        check("active", progModeActive, 8'h01);
        prog.load(2'h2, 1'b0, 8'h02);
        prog.load(2'h0, 1'b1, 8'h0F);
        prog.load(2'h0, 1'b0, 8'hFF);
        prog.read(1'b0, rd, en);
        check("flash low", rd, 8'hFF);
        check("flash low en", en, 8'h01);
        prog.read(1'b1, rd, en);
        check("flash high", rd, 8'hFF);
        check("released", dataOutEnable, 8'h00);
        prog.load(2'h0, 1'b0, 8'h00);
        prog.read(1'b0, rd, en);
        check("flash reuse", {en, rd[6:0]}, 8'hFF);
        $display("test flash done");
    endtask
    task automatic t_eeprom();
        prog.load(2'h2, 1'b0, 8'h03);
        prog.load(2'h0, 1'b1, 8'h01);
        prog.load(2'h0, 1'b0, 8'hFF);
        prog.read(1'b0, rd, en);
        check("eeprom", {en, rd[6:0]}, 8'hFF);
        prog.read(1'b1, rd, en);
        check("eeprom bs1 en", en, 8'h00);
        $display("test eeprom done");
    endtask
    task automatic t_fuse();
        prog.strobe();
        check("ready other cmd", readyBusyPin, 8'h01);
        prog.load(2'h2, 1'b0, 8'h40);
        prog.load(2'h1, 1'b0, 8'hA5);
        prog.strobe();
        check("busy", readyBusyPin, 8'h00);
        prog.waitReady(n);
        // Busy lasts FWC cycles; the strobe task returns two cycles into it.
        check("busy cycles", 8'(n), 8'(FWC - 1));
        check("ready", readyBusyPin, 8'h01);
        prog.load(2'h2, 1'b0, 8'h04);
        prog.read(1'b0, rd, en);
        check("fuse", rd, 8'hA5);
        $display("test fuse done");
    endtask
    initial begin
        reset = 1'b1;
        repeat (8) @(posedge sys_clk);
        reset <= 1'b0;
        repeat (3) @(posedge sys_clk);
        t_refuse();
        t_flash();
        t_eeprom();
        t_fuse();
        finish_test();
    end
endmodule
`default_nettype wire
